// [core/stcp_timer.sv]
// Module: 16-bit compare/PWM timer with APB register slave
// Function
// - Period byte compares counter upper byte only
// - Period match every value*256, zero gives 65536
// - Zero period value lets counter overflow
// - 16-bit compare-A from two bytes, full compare
// - Mode 00: compare-match output, two clear sources
// - Clear-select low: period clear, both flags
// - Clear-select high: A clear, A flag only
// - Compare-A zero: overflow at FFFF, no flag
// - Pin changes only on compare-A match or enable rise
// - A match drives pin high, low, toggle
// - Pin field: none, low, high, toggle
// - Enable rise loads initial pin level
// - Enable rise zeroes counter, fall freezes it
// - Mode 11 counts like 00, pin undriven
// - Mode 10 PWM, swap bit picks roles
// - PWM raises both flags on matches
// - PWM: active level, pin force, inversion
// - Swap 0: period from byte, duty compare-A
// - Duty at or above period: 100%
// - Swap 1: period compare-A, duty from byte
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module stcp_timer (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [stcp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [stcp_pkg::DATA_W-1:0] pwdata,
  output logic      [stcp_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Timer output pin
  output logic                             pin_out,
  output logic                             pin_oe,
  // Match flags
  output logic                             a_match_flag,
  output logic                             p_match_flag
);
  import stcp_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  stcp_state_t s_q;
  stcp_state_t s_d;

  logic [1:0]  mode;
  logic [1:0]  pin_fn;
  logic        oc;
  logic        pol;
  logic        dpx;
  logic        cclr;
  logic        pwm;
  logic        cmp;
  logic        en_rise;
  logic        running;
  logic [15:0] cmpa_m1;
  logic [7:0]  hi_inc;
  logic        a_hit;
  logic        p_hit;
  logic        clr;
  logic        a_ev;
  logic        p_ev;
  logic [16:0] duty;
  logic        active;
  logic        lvl;
  logic        next_pin;
  logic        addr_ok;
  logic [31:0] rd;
  logic        do_wr;
  logic [1:0]  w1c;
  logic        wr_ctl0;
  logic        wr_ctl1;
  logic        wr_cmpa_l;
  logic        wr_cmpa_h;
  logic        wr_per;
  logic        wr_stat;
  logic [1:0]  flag_set;
  logic [1:0]  flag_nxt;
  logic        drv_out;
  logic        drv_oe;

  // ************************************************************
  // Control fields
  // ************************************************************
  assign mode    = s_q.ctl1[CTL1_MODE_HI:CTL1_MODE_LO];
  assign pin_fn  = s_q.ctl1[CTL1_FN_HI:CTL1_FN_LO];
  assign oc      = s_q.ctl1[CTL1_OC];
  assign pol     = s_q.ctl1[CTL1_POL];
  assign dpx     = s_q.ctl1[CTL1_DPX];
  assign cclr    = s_q.ctl1[CTL1_CCLR];
  assign pwm     = (mode == MODE_PWM);
  // Undefined mode code 01 behaves as timer mode
  assign cmp     = (mode == MODE_CMP);

  // ************************************************************
  // Enable edge and run condition
  // ************************************************************
  // Edge seen one cycle after the enabling write lands
  assign en_rise = s_q.en & ~s_q.en_prev;
  // A falling enable or pause simply stops counting: value held
  assign running = s_q.en & s_q.en_prev & ~s_q.pause;

  // ************************************************************
  // Comparators
  // ************************************************************
  // Matching one count early makes the period exact, with no
  // extra cycle spent at the compare value before the clear.
  assign cmpa_m1 = s_q.cmpa - 16'h0001;
  // Zero compare-A never matches; the counter wraps at ffff
  assign a_hit   = (s_q.cmpa != 16'h0000) && (s_q.cnt == cmpa_m1);
  assign hi_inc  = s_q.cnt[15:8] + 8'h01;
  // Upper byte only: matches fall on 256-count boundaries, and
  // a zero value meets the natural wrap at ffff
  assign p_hit   = (s_q.cnt[7:0] == 8'hff) && (hi_inc == s_q.per);

  always_comb begin
    if (pwm) begin
      clr = dpx ? a_hit : p_hit;
    end else if (cclr) begin
      clr = a_hit;
    end else begin
      clr = p_hit;
    end
  end

  // Flags and clear act in the matching cycle
  assign a_ev = running & a_hit;
  assign p_ev = running & p_hit & (pwm | ~cclr);

  // ************************************************************
  // PWM waveform
  // ************************************************************
  // With swap set, duty from the period byte: value*256, zero meaning 65536; else compare-A
  always_comb begin
    if (dpx) begin
      duty = {(s_q.per == 8'h00), s_q.per, 8'h00};
    end else begin
      duty = {1'b0, s_q.cmpa};
    end
  end

  // Count never reaches the period, so duty >= period stays active
  assign active = ({1'b0, s_q.cnt} < duty);

  always_comb begin
    case (pin_fn)
      FN_NONE: lvl = ~oc;
      FN_LOW:  lvl = oc;
      default: lvl = active ? oc : ~oc;
    endcase
  end

  // ************************************************************
  // Compare-mode pin state
  // ************************************************************
  always_comb begin
    next_pin = s_q.pin;
    if (en_rise) begin
      next_pin = oc;
    end else if (cmp && a_ev) begin
      case (pin_fn)
        FN_LOW:  next_pin = 1'b0;
        FN_HIGH: next_pin = 1'b1;
        FN_TOG:  next_pin = ~s_q.pin;
        default: next_pin = s_q.pin;
      endcase
    end
  end

  // ************************************************************
  // Register read decode
  // ************************************************************
  always_comb begin
    rd      = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr == OFS_CTL0) begin
      rd[CTL0_PAUSE]              = s_q.pause;
      rd[CTL0_CLK_HI:CTL0_CLK_LO] = s_q.clksel;
      rd[CTL0_ENABLE]             = s_q.en;
    end else if (paddr == OFS_CTL1) begin
      rd[7:0] = s_q.ctl1;
    end else if (paddr == OFS_CNT_LO) begin
      rd[7:0] = s_q.cnt[7:0];
    end else if (paddr == OFS_CNT_HI) begin
      rd[7:0] = s_q.cnt[15:8];
    end else if (paddr == OFS_CMPA_L) begin
      rd[7:0] = s_q.cmpa[7:0];
    end else if (paddr == OFS_CMPA_H) begin
      rd[7:0] = s_q.cmpa[15:8];
    end else if (paddr == OFS_PERIOD) begin
      rd[7:0] = s_q.per;
    end else if (paddr == OFS_STATUS) begin
      rd[STAT_A_FLAG] = s_q.flags[0];
      rd[STAT_P_FLAG] = s_q.flags[1];
      rd[STAT_PIN]    = s_q.out;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Write lands at the access edge with pready already high
  assign do_wr = psel & penable & pwrite & s_q.pready & ~s_q.pslverr;

  // ************************************************************
  // Register write decode
  // ************************************************************
  // One strobe per register keeps the next-state logic flat; the
  // counter bytes get none, so writes there fall away silently
  always_comb begin
    wr_ctl0   = 1'b0;
    wr_ctl1   = 1'b0;
    wr_cmpa_l = 1'b0;
    wr_cmpa_h = 1'b0;
    wr_per    = 1'b0;
    wr_stat   = 1'b0;
    if (do_wr && (paddr == OFS_CTL0)) begin
      wr_ctl0 = 1'b1;
    end else if (do_wr && (paddr == OFS_CTL1)) begin
      wr_ctl1 = 1'b1;
    end else if (do_wr && (paddr == OFS_CMPA_L)) begin
      wr_cmpa_l = 1'b1;
    end else if (do_wr && (paddr == OFS_CMPA_H)) begin
      wr_cmpa_h = 1'b1;
    end else if (do_wr && (paddr == OFS_PERIOD)) begin
      wr_per = 1'b1;
    end else if (do_wr && (paddr == OFS_STATUS)) begin
      wr_stat = 1'b1;
    end
  end

  assign w1c   = wr_stat ? {pwdata[STAT_P_FLAG], pwdata[STAT_A_FLAG]} : 2'b00;

  // ************************************************************
  // Match flags
  // ************************************************************
  assign flag_set = {p_ev, a_ev};

  // Hardware set beats a same-cycle software clear; a status write
  // clears only the bits written as one
  generate
    for (genvar i = 0; i < 2; i++) begin : g_flag
      assign flag_nxt[i] = flag_set[i] | (s_q.flags[i] & ~w1c[i]);
    end
  endgenerate

  // ************************************************************
  // Pin driver
  // ************************************************************
  // Polarity applies after the level is picked, so initial and
  // forced levels invert alike; timer mode leaves the pin undriven
  always_comb begin
    if (cmp) begin
      drv_out = next_pin ^ pol;
      drv_oe  = 1'b1;
    end else if (pwm) begin
      drv_out = lvl ^ pol;
      drv_oe  = 1'b1;
    end else begin
      drv_out = 1'b0;
      drv_oe  = 1'b0;
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_d = s_q;

    // Bus handshake: one access cycle, answer registered
    case (s_q.bus)
      STCP_BUS_IDLE: begin
        if (psel && !penable) begin
          s_d.bus     = STCP_BUS_ACK;
          s_d.pready  = 1'b1;
          s_d.pslverr = ~addr_ok;
          s_d.prdata  = pwrite ? 32'h0000_0000 : rd;
        end
      end
      default: begin
        if (psel && penable) begin
          s_d.bus     = STCP_BUS_IDLE;
          s_d.pready  = 1'b0;
          s_d.pslverr = 1'b0;
        end
      end
    endcase

    // Register writes; counter bytes are read only
    if (wr_ctl0) begin
      s_d.pause  = pwdata[CTL0_PAUSE];
      s_d.clksel = pwdata[CTL0_CLK_HI:CTL0_CLK_LO];
      s_d.en     = pwdata[CTL0_ENABLE];
    end
    if (wr_ctl1) begin
      s_d.ctl1 = pwdata[7:0];
    end
    if (wr_cmpa_l) begin
      s_d.cmpa[7:0] = pwdata[7:0];
    end
    if (wr_cmpa_h) begin
      s_d.cmpa[15:8] = pwdata[7:0];
    end
    if (wr_per) begin
      s_d.per = pwdata[7:0];
    end

    // Counter
    s_d.en_prev = s_q.en;
    if (en_rise) begin
      s_d.cnt = 16'h0000;
    end else if (running) begin
      s_d.cnt = clr ? 16'h0000 : s_q.cnt + 16'h0001;
    end

    // Flags and pin come from their own sections
    s_d.flags = flag_nxt;
    s_d.pin   = next_pin;
    s_d.out   = drv_out;
    s_d.oe    = drv_oe;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.bus     <= STCP_BUS_IDLE;
      s_q.pready  <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.prdata  <= 32'h0000_0000;
      s_q.en      <= 1'b0;
      s_q.en_prev <= 1'b0;
      s_q.pause   <= 1'b0;
      s_q.clksel  <= 3'h0;
      s_q.ctl1    <= RST_CTL1;
      s_q.cmpa    <= RST_CMPA;
      s_q.per     <= RST_PER;
      s_q.cnt     <= 16'h0000;
      s_q.flags   <= 2'h0;
      s_q.pin     <= 1'b0;
      s_q.out     <= 1'b0;
      s_q.oe      <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign prdata       = s_q.prdata;
  assign pready       = s_q.pready;
  assign pslverr      = s_q.pslverr;
  assign pin_out      = s_q.out;
  assign pin_oe       = s_q.oe;
  assign a_match_flag = s_q.flags[0];
  assign p_match_flag = s_q.flags[1];

endmodule // stcp_timer

`default_nettype wire

// [shared/stcp_pkg.sv]
// Package: register map, field layout and types of the compare/PWM timer
`default_nettype none

package stcp_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_CTL0   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTL1   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CNT_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CNT_HI = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CMPA_L = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CMPA_H = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1c;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTL0_PAUSE  = 7;
  localparam int CTL0_CLK_HI = 6;
  localparam int CTL0_CLK_LO = 4;
  localparam int CTL0_ENABLE = 3;
  localparam int CTL1_MODE_HI = 7;
  localparam int CTL1_MODE_LO = 6;
  localparam int CTL1_FN_HI   = 5;
  localparam int CTL1_FN_LO   = 4;
  localparam int CTL1_OC      = 3;
  localparam int CTL1_POL     = 2;
  localparam int CTL1_DPX     = 1;
  localparam int CTL1_CCLR    = 0;
  localparam int STAT_A_FLAG  = 0;
  localparam int STAT_P_FLAG  = 1;
  localparam int STAT_PIN     = 2;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0]  RST_CTL1 = 8'h00;
  localparam logic [15:0] RST_CMPA = 16'h0000;
  localparam logic [7:0]  RST_PER  = 8'h00;

  // ************************************************************
  // Modes and pin functions
  // ************************************************************
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  localparam logic [1:0] FN_NONE  = 2'h0;
  localparam logic [1:0] FN_LOW   = 2'h1;
  localparam logic [1:0] FN_HIGH  = 2'h2;
  localparam logic [1:0] FN_TOG   = 2'h3;

  typedef enum logic [1:0] {
    STCP_BUS_IDLE = 2'b00,
    STCP_BUS_ACK  = 2'b01
  } stcp_bus_t;

  typedef struct packed {
    stcp_bus_t         bus;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
    logic              en;
    logic              en_prev;
    logic              pause;
    logic [2:0]        clksel;
    logic [7:0]        ctl1;
    logic [15:0]       cmpa;
    logic [7:0]        per;
    logic [15:0]       cnt;
    logic [1:0]        flags;
    logic              pin;
    logic              out;
    logic              oe;
  } stcp_state_t;

endpackage

`default_nettype wire

// [tb/stcp_timer_monitor.sv]
// Checker: bus and pin relations of the compare/PWM timer
`timescale 1ns/100ps
`default_nettype none
module stcp_timer_monitor (
  // Clock and reset
  input wire logic                        pclk,
  input wire logic                        presetn,
  // APB
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [stcp_pkg::ADDR_W-1:0] paddr,
  input wire logic [stcp_pkg::DATA_W-1:0] pwdata,
  input wire logic [stcp_pkg::DATA_W-1:0] prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  // Pin and flags
  input wire logic                        pin_out,
  input wire logic                        pin_oe,
  input wire logic                        a_match_flag,
  input wire logic                        p_match_flag
);
  import stcp_pkg::*;
  // ****
  // Shadows of the written setup
  // ****
  logic [1:0]  mode_q, fn_q;
  logic        en_q, oc_q, pol_q, clr_q;
  logic [15:0] cmpa_q;
  wire logic   wr = psel && penable && pwrite && pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {en_q, mode_q, fn_q, oc_q, pol_q, clr_q, cmpa_q} <= '0;
    end else if (wr) begin
      if (paddr == OFS_CTL0) en_q <= pwdata[CTL0_ENABLE];
      if (paddr == OFS_CTL1) {mode_q, fn_q, oc_q, pol_q} <= pwdata[7:2];
      if (paddr == OFS_CTL1) clr_q <= pwdata[CTL1_CCLR];
      if (paddr == OFS_CMPA_L) cmpa_q[7:0] <= pwdata[7:0];
      if (paddr == OFS_CMPA_H) cmpa_q[15:8] <= pwdata[7:0];
    end
  end
  // Pin level after a compare-A match, from the previous level
  function automatic logic lvl(input logic [1:0] f, input logic p);
    return f == FN_NONE ? p : f == FN_LOW ? 1'b0 : f == FN_HIGH ? 1'b1 : !p;
  endfunction
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse:
    assert property (psel && !penable |=> pready ##1 !pready) else $error("pready not one cycle");
  a_err_unmapped:
    assert property (psel && !penable && paddr > OFS_STATUS |=> pready && pslverr)
    else $error("no error on unmapped access");
  a_flag_sticky:
    assert property ($fell(a_match_flag) |-> $past(wr && paddr == OFS_STATUS && pwdata[0]))
    else $error("a flag lost without clear");
  a_pflag_cclr:
    assert property ($rose(p_match_flag) |-> !($past(clr_q) && $past(mode_q) != MODE_PWM))
    else $error("p flag with clear on a");
  a_aflag_zero:
    assert property ($rose(a_match_flag) && $past(mode_q) != MODE_PWM |-> $past(cmpa_q) != 16'h0000)
    else $error("a flag with zero compare");
  a_tmr_no_oe:
    assert property ($past(mode_q) == MODE_TMR |-> !pin_oe) else $error("pin driven in timer mode");
  a_en_pin_load:
    assert property ($rose(en_q) && mode_q == MODE_CMP |=> pin_out == (oc_q ^ pol_q))
    else $error("pin not at initial level");
  a_cmp_pin_fn:
    assert property ($rose(a_match_flag) && $past(mode_q) == MODE_CMP && $past(en_q)
      |-> pin_out == (lvl($past(fn_q), $past(pin_out) ^ $past(pol_q)) ^ $past(pol_q)))
    else $error("wrong pin on a match");
  a_pwm_force:
    assert property ($past(mode_q) == MODE_PWM && $past(fn_q) == FN_NONE && $past(en_q)
      && $past(en_q, 2) |-> pin_out == ($past(oc_q) ~^ $past(pol_q))) else $error("pwm idle level");
endmodule // stcp_timer_monitor

bind stcp_timer stcp_timer_monitor u_stcp_timer_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
  .a_match_flag(a_match_flag), .p_match_flag(p_match_flag));
`default_nettype wire

// [tb/stcp_timer_test.sv]
// Testbench: register and timer scenarios of the compare/PWM timer
`timescale 1ns/100ps
`default_nettype none
module stcp_timer_test;
  import stcp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, n;
  logic        pready, pslverr, pin_out, pin_oe, a_match_flag, p_match_flag;
  int          err_count, comparisons, cycles;
  // PWM cases: control, compare-A, flag waited on, delay, window, high count, other flag
  logic [7:0]  pc [5] = '{8'ha9, 8'had, 8'ha9, 8'hab, 8'h89};
  logic [15:0] pa [5] = '{16'h0040, 16'h0040, 16'h012c, 16'h0200, 16'h0040};
  logic        pf [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [31:0] pn [5] = '{32'h101, 32'h101, 32'h101, 32'h201, 32'h101};
  logic [31:0] pw [5] = '{32'h100, 32'h100, 32'h100, 32'h200, 32'h100};
  logic [31:0] ph [5] = '{32'h40, 32'hc0, 32'h100, 32'h100, 32'h0};
  logic        po [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [7:0]  ra [4] = '{OFS_CMPA_L, OFS_CMPA_H, OFS_PERIOD, OFS_CNT_LO};
  logic [31:0] rv [4] = '{32'ha5, 32'h5a, 32'h3c, 32'hff};
  logic [31:0] re [4] = '{32'ha5, 32'h5a, 32'h3c, 32'h0};

  stcp_timer u_stcp_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe), .a_match_flag(a_match_flag),
    .p_match_flag(p_match_flag));

  always #50 pclk = ~pclk;
  // Longest case is the full 16-bit wrap, so the ceiling sits above it
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      err_count = err_count + 1;
      report_and_stop();
    end
  end
  // ****
  // Tasks
  // ****
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_flag(input logic sel_p);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while ((sel_p ? p_match_flag : a_match_flag) !== 1'b1 && n < 70000);
  endtask
  task automatic wait_pin();
    logic v;
    v = pin_out;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (pin_out === v && n < 70000);
  endtask
  task automatic count_high(input logic [31:0] len);
    n = 0;
    repeat (len) begin
      @(posedge pclk);
      #1;
      n = n + {31'h0, pin_out};
    end
  endtask
  // Stop, reprogram, clear flags and restart, so the counter starts from zero
  task automatic start(input logic [7:0] ctl, input logic [15:0] ca, input logic [7:0] per);
    apb(1'b1, OFS_CTL0, 32'h0);
    apb(1'b1, OFS_CTL1, {24'h0, ctl});
    apb(1'b1, OFS_CMPA_L, {24'h0, ca[7:0]});
    apb(1'b1, OFS_CMPA_H, {24'h0, ca[15:8]});
    apb(1'b1, OFS_PERIOD, {24'h0, per});
    apb(1'b1, OFS_STATUS, 32'h3);
    apb(1'b1, OFS_CTL0, 32'h8);
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    {pclk, presetn, psel, penable, pwrite} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cycles = 0;
    err_count = 0;
    comparisons = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, {i[5:0], 2'b00}, 32'h0);
      chk("reset value", 32'h0, rd);
    end
    for (int i = 0; i < 4; i++) apb(1'b1, ra[i], rv[i]);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("read back", re[i], rd);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    start(8'h39, 16'h012c, 8'h01);
    wait_flag(1'b0);
    chk("a match delay", 32'h12d, n);
    chk("toggled pin", 32'h0, {31'h0, pin_out});
    wait_pin();
    chk("a clear period", 32'h12c, n);
    chk("p flag", 32'h0, {31'h0, p_match_flag});
    start(8'h38, 16'h0064, 8'h01);
    wait_flag(1'b1);
    chk("p match delay", 32'h101, n);
    chk("a flag", 32'h1, {31'h0, a_match_flag});
    wait_pin();
    chk("pin after clear", 32'h64, n);
    wait_pin();
    chk("pin period", 32'h100, n);
    for (int f = 0; f < 4; f++) begin
      start({2'b00, f[1:0], ~f[1], 3'b001}, 16'h0008, 8'h00);
      wait_flag(1'b0);
      chk("restart delay", 32'h9, n);
      chk("pin function", {31'h0, f != 1}, {31'h0, pin_out});
    end
    for (int k = 0; k < 5; k++) begin
      start(pc[k], pa[k], 8'h01);
      wait_flag(pf[k]);
      chk("pwm flag delay", pn[k], n);
      chk("other flag", {31'h0, po[k]}, {31'h0, pf[k] ? a_match_flag : p_match_flag});
      count_high(pw[k]);
      chk("pwm high count", ph[k], n);
    end
    start(8'hc0, 16'h0000, 8'h00);
    wait_flag(1'b1);
    chk("overflow period", 32'h10001, n);
    chk("a flag at zero", 32'h0, {31'h0, a_match_flag});
    chk("pin enable", 32'h0, {31'h0, pin_oe});
    apb(1'b1, OFS_CTL0, 32'h0);
    repeat (20) @(posedge pclk);
    apb(1'b0, OFS_CNT_LO, 32'h0);
    chk("frozen count", 32'h3, rd);
    report_and_stop();
  end
endmodule // stcp_timer_test
`default_nettype wire
